// [hw/charger_flags_map.vh]
`ifndef CHARGER_FLAGS_MAP_VH
`define CHARGER_FLAGS_MAP_VH

// Register offsets on the serial control port
`define FAULT_STATUS_ONE_ADDR 8'h21
`define CHARGER_EVENT_FLAGS_ZERO_ADDR 8'h22
`define CHARGER_EVENT_FLAGS_ONE_ADDR 8'h23
`define CHARGER_EVENT_FLAGS_TWO_ADDR 8'h24

// Reset values
`define FAULT_STATUS_ONE_RESET 8'h00
`define CHARGER_EVENT_FLAGS_ZERO_RESET 8'h00
`define CHARGER_EVENT_FLAGS_ONE_RESET 8'h00
`define CHARGER_EVENT_FLAGS_TWO_RESET 8'h00

// Fault status one fields
`define SYSTEM_RAIL_SHORT_STATE_BIT 7
`define SYSTEM_RAIL_OVERVOLT_STATE_BIT 6
`define OTG_OUTPUT_OVERVOLT_STATE_BIT 5
`define OTG_OUTPUT_UNDERVOLT_STATE_BIT 4
`define DIE_SHUTDOWN_STATE_BIT 2

// Event flags zero fields
`define INPUT_CURRENT_LIMIT_EVENT_BIT 7
`define INPUT_VOLTAGE_LIMIT_EVENT_BIT 6
`define WATCHDOG_EXPIRY_EVENT_BIT 5
`define WEAK_SOURCE_EVENT_BIT 4
`define POWER_GOOD_CHANGE_EVENT_BIT 3
`define SECOND_INPUT_PRESENCE_EVENT_BIT 2
`define FIRST_INPUT_PRESENCE_EVENT_BIT 1
`define BUS_INPUT_PRESENCE_EVENT_BIT 0

// Event flags one fields
`define CHARGE_STATE_CHANGE_EVENT_BIT 7
`define CURRENT_OPTIMIZER_CHANGE_EVENT_BIT 6
`define BUS_SOURCE_TYPE_CHANGE_EVENT_BIT 4
`define DIE_TEMP_REGULATION_EVENT_BIT 2
`define BATTERY_PRESENCE_EVENT_BIT 1
`define PORT_DETECTION_CHANGE_EVENT_BIT 0

// Event flags two fields
`define DATA_LINE_DETECT_DONE_BIT 6
`define CONVERSION_DONE_EVENT_BIT 5
`define MIN_SYSTEM_REGULATION_EVENT_BIT 4
`define FAST_CHARGE_TIMEOUT_EVENT_BIT 3
`define TRICKLE_TIMEOUT_EVENT_BIT 2
`define PRECHARGE_TIMEOUT_EVENT_BIT 1
`define FINAL_PHASE_TIMEOUT_EVENT_BIT 0

`endif

// [hw/charger_fault_and_event_flags.v]
`timescale 1ns/1ns
`include "charger_flags_map.vh"

module charger_fault_and_event_flags #(
   parameter CHARGE_STATE_WIDTH = 3,
   parameter OPTIMIZER_WIDTH = 2,
   parameter SOURCE_TYPE_WIDTH = 4,
   parameter DETECTION_WIDTH = 4
) (
   input wire clk_i,
   input wire reset_i,
   input wire rd_en_i,
   input wire [7:0] rd_addr_i,
   output reg [7:0] rd_data_o,
   output reg rd_valid_o,
   input wire system_rail_short_state_i,
   input wire system_rail_overvolt_state_i,
   input wire otg_output_overvolt_state_i,
   input wire otg_output_undervolt_state_i,
   input wire die_shutdown_state_i,
   input wire input_current_regulation_i,
   input wire otg_current_regulation_i,
   input wire input_voltage_regulation_i,
   input wire otg_voltage_regulation_i,
   input wire watchdog_expired_i,
   input wire weak_source_i,
   input wire power_good_state_i,
   input wire second_input_present_i,
   input wire first_input_present_i,
   input wire bus_input_present_i,
   input wire [CHARGE_STATE_WIDTH-1:0] charge_state_i,
   input wire [OPTIMIZER_WIDTH-1:0] input_current_optimizer_i,
   input wire [SOURCE_TYPE_WIDTH-1:0] bus_source_type_i,
   input wire die_temp_regulation_i,
   input wire battery_present_i,
   input wire [DETECTION_WIDTH-1:0] port_detection_i,
   input wire data_line_detect_complete_i,
   input wire conversion_done_i,
   input wire single_conversion_mode_i,
   input wire minimum_system_voltage_i,
   input wire fast_charge_timer_expired_i,
   input wire trickle_timer_expired_i,
   input wire precharge_timer_expired_i,
   input wire final_phase_timer_expired_i
);

   reg [7:0] charger_event_flags_zero;
   reg [7:0] charger_event_flags_one;
   reg [7:0] charger_event_flags_two;

   // Previous samples for edge and change detection
   reg prev_current_reg;
   reg prev_voltage_reg;
   reg prev_watchdog;
   reg prev_weak_source;
   reg prev_power_good;
   reg prev_second_input;
   reg prev_first_input;
   reg prev_bus_input;
   reg [CHARGE_STATE_WIDTH-1:0] prev_charge_state;
   reg [OPTIMIZER_WIDTH-1:0] prev_optimizer;
   reg [SOURCE_TYPE_WIDTH-1:0] prev_source_type;
   reg prev_die_temp_reg;
   reg prev_battery;
   reg [DETECTION_WIDTH-1:0] prev_port_detection;
   reg prev_line_detect;
   reg prev_conversion;
   reg prev_min_system;
   reg prev_fast_timer;
   reg prev_trickle_timer;
   reg prev_precharge_timer;
   reg prev_final_timer;

   wire current_reg = input_current_regulation_i | otg_current_regulation_i;
   wire voltage_reg = input_voltage_regulation_i | otg_voltage_regulation_i;

   reg [7:0] fault_status_one;
   reg [7:0] set_zero;
   reg [7:0] set_one;
   reg [7:0] set_two;
   reg [7:0] read_data;

   wire read_zero = rd_en_i && (rd_addr_i == `CHARGER_EVENT_FLAGS_ZERO_ADDR);
   wire read_one = rd_en_i && (rd_addr_i == `CHARGER_EVENT_FLAGS_ONE_ADDR);
   wire read_two = rd_en_i && (rd_addr_i == `CHARGER_EVENT_FLAGS_TWO_ADDR);

   // Live fault status, reserved bits read zero
   always @* begin
      fault_status_one = `FAULT_STATUS_ONE_RESET;
      fault_status_one[`SYSTEM_RAIL_SHORT_STATE_BIT] = system_rail_short_state_i;
      fault_status_one[`SYSTEM_RAIL_OVERVOLT_STATE_BIT] = system_rail_overvolt_state_i;
      fault_status_one[`OTG_OUTPUT_OVERVOLT_STATE_BIT] = otg_output_overvolt_state_i;
      fault_status_one[`OTG_OUTPUT_UNDERVOLT_STATE_BIT] = otg_output_undervolt_state_i;
      fault_status_one[`DIE_SHUTDOWN_STATE_BIT] = die_shutdown_state_i;
   end

   // Events detected this cycle
   always @* begin
      set_zero = 8'h00;
      set_one = 8'h00;
      set_two = 8'h00;
      set_zero[`INPUT_CURRENT_LIMIT_EVENT_BIT] = current_reg & ~prev_current_reg;
      set_zero[`INPUT_VOLTAGE_LIMIT_EVENT_BIT] = voltage_reg & ~prev_voltage_reg;
      set_zero[`WATCHDOG_EXPIRY_EVENT_BIT] = watchdog_expired_i & ~prev_watchdog;
      set_zero[`WEAK_SOURCE_EVENT_BIT] = weak_source_i & ~prev_weak_source;
      set_zero[`POWER_GOOD_CHANGE_EVENT_BIT] = power_good_state_i ^ prev_power_good;
      set_zero[`SECOND_INPUT_PRESENCE_EVENT_BIT] = second_input_present_i ^ prev_second_input;
      set_zero[`FIRST_INPUT_PRESENCE_EVENT_BIT] = first_input_present_i ^ prev_first_input;
      set_zero[`BUS_INPUT_PRESENCE_EVENT_BIT] = bus_input_present_i ^ prev_bus_input;
      set_one[`CHARGE_STATE_CHANGE_EVENT_BIT] = (charge_state_i != prev_charge_state);
      set_one[`CURRENT_OPTIMIZER_CHANGE_EVENT_BIT] = (input_current_optimizer_i != prev_optimizer);
      set_one[`BUS_SOURCE_TYPE_CHANGE_EVENT_BIT] = (bus_source_type_i != prev_source_type);
      set_one[`DIE_TEMP_REGULATION_EVENT_BIT] = die_temp_regulation_i & ~prev_die_temp_reg;
      set_one[`BATTERY_PRESENCE_EVENT_BIT] = battery_present_i ^ prev_battery;
      set_one[`PORT_DETECTION_CHANGE_EVENT_BIT] = (port_detection_i != prev_port_detection);
      set_two[`DATA_LINE_DETECT_DONE_BIT] = data_line_detect_complete_i & ~prev_line_detect;
      set_two[`CONVERSION_DONE_EVENT_BIT] = conversion_done_i & ~prev_conversion & single_conversion_mode_i;
      set_two[`MIN_SYSTEM_REGULATION_EVENT_BIT] = minimum_system_voltage_i ^ prev_min_system;
      set_two[`FAST_CHARGE_TIMEOUT_EVENT_BIT] = fast_charge_timer_expired_i & ~prev_fast_timer;
      set_two[`TRICKLE_TIMEOUT_EVENT_BIT] = trickle_timer_expired_i & ~prev_trickle_timer;
      set_two[`PRECHARGE_TIMEOUT_EVENT_BIT] = precharge_timer_expired_i & ~prev_precharge_timer;
      set_two[`FINAL_PHASE_TIMEOUT_EVENT_BIT] = final_phase_timer_expired_i & ~prev_final_timer;
   end

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_current_reg <= 1'b0;
         prev_voltage_reg <= 1'b0;
         prev_watchdog <= 1'b0;
         prev_weak_source <= 1'b0;
         prev_power_good <= 1'b0;
         prev_second_input <= 1'b0;
         prev_first_input <= 1'b0;
         prev_bus_input <= 1'b0;
         prev_charge_state <= {CHARGE_STATE_WIDTH{1'b0}};
         prev_optimizer <= {OPTIMIZER_WIDTH{1'b0}};
         prev_source_type <= {SOURCE_TYPE_WIDTH{1'b0}};
         prev_die_temp_reg <= 1'b0;
         prev_battery <= 1'b0;
         prev_port_detection <= {DETECTION_WIDTH{1'b0}};
         prev_line_detect <= 1'b0;
         prev_conversion <= 1'b0;
         prev_min_system <= 1'b0;
         prev_fast_timer <= 1'b0;
         prev_trickle_timer <= 1'b0;
         prev_precharge_timer <= 1'b0;
         prev_final_timer <= 1'b0;
      end else begin
         prev_current_reg <= current_reg;
         prev_voltage_reg <= voltage_reg;
         prev_watchdog <= watchdog_expired_i;
         prev_weak_source <= weak_source_i;
         prev_power_good <= power_good_state_i;
         prev_second_input <= second_input_present_i;
         prev_first_input <= first_input_present_i;
         prev_bus_input <= bus_input_present_i;
         prev_charge_state <= charge_state_i;
         prev_optimizer <= input_current_optimizer_i;
         prev_source_type <= bus_source_type_i;
         prev_die_temp_reg <= die_temp_regulation_i;
         prev_battery <= battery_present_i;
         prev_port_detection <= port_detection_i;
         prev_line_detect <= data_line_detect_complete_i;
         prev_conversion <= conversion_done_i;
         prev_min_system <= minimum_system_voltage_i;
         prev_fast_timer <= fast_charge_timer_expired_i;
         prev_trickle_timer <= trickle_timer_expired_i;
         prev_precharge_timer <= precharge_timer_expired_i;
         prev_final_timer <= final_phase_timer_expired_i;
      end
   end

   // Sticky flags: cleared by a read of their register, a new event in that cycle wins
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         charger_event_flags_zero <= `CHARGER_EVENT_FLAGS_ZERO_RESET;
         charger_event_flags_one <= `CHARGER_EVENT_FLAGS_ONE_RESET;
         charger_event_flags_two <= `CHARGER_EVENT_FLAGS_TWO_RESET;
      end else begin
         charger_event_flags_zero <= set_zero | (read_zero ? 8'h00 : charger_event_flags_zero);
         charger_event_flags_one <= set_one | (read_one ? 8'h00 : charger_event_flags_one);
         charger_event_flags_two <= set_two | (read_two ? 8'h00 : charger_event_flags_two);
      end
   end

   // Read decode, unmapped offsets return zero
   always @* begin
      case (rd_addr_i)
         `FAULT_STATUS_ONE_ADDR: read_data = fault_status_one;
         `CHARGER_EVENT_FLAGS_ZERO_ADDR: read_data = charger_event_flags_zero;
         `CHARGER_EVENT_FLAGS_ONE_ADDR: read_data = charger_event_flags_one;
         `CHARGER_EVENT_FLAGS_TWO_ADDR: read_data = charger_event_flags_two;
         default: read_data = 8'h00;
      endcase
   end

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rd_data_o <= 8'h00;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_en_i;
         if (rd_en_i) begin
            rd_data_o <= read_data;
         end
      end
   end

endmodule

// [test/charger_flags_properties.sv]
`timescale 1ns/1ns
module charger_flags_properties (
   input logic clk_i,
   input logic reset_i,
   input logic rd_en_i,
   input logic [7:0] rd_addr_i,
   input logic [7:0] rd_data_o,
   input logic rd_valid_o,
   input logic system_rail_short_state_i,
   input logic system_rail_overvolt_state_i,
   input logic die_shutdown_state_i,
   input logic watchdog_expired_i,
   input logic power_good_state_i,
   input logic conversion_done_i,
   input logic single_conversion_mode_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   wire rd21 = rd_en_i && rd_addr_i == 8'h21;
   wire rd22 = rd_en_i && rd_addr_i == 8'h22;
   wire rd24 = rd_en_i && rd_addr_i == 8'h24;
   short_live_a: assert property (rd21 |=> rd_data_o[7] == $past(system_rail_short_state_i))
      else $error("short state bit wrong");
   overvolt_live_a: assert property (rd21 |=> rd_data_o[6] == $past(system_rail_overvolt_state_i))
      else $error("overvoltage bit wrong");
   shutdown_live_a: assert property (rd21 |=> rd_data_o[2] == $past(die_shutdown_state_i)
      && {rd_data_o[3], rd_data_o[1:0]} == 3'h0) else $error("shutdown or reserved bits wrong");
   wdog_flag_a: assert property ($rose(watchdog_expired_i) ##1 rd22 |=> rd_data_o[5])
      else $error("watchdog flag missing");
   pg_change_a: assert property ($changed(power_good_state_i) ##1 rd22 |=> rd_data_o[3])
      else $error("power good flag missing");
   conv_single_a: assert property ($rose(conversion_done_i) && single_conversion_mode_i ##1 rd24
      |=> rd_data_o[5]) else $error("conversion flag missing");
   read_clear_a: assert property ((rd22 && !$rose(watchdog_expired_i) && !$past(reset_i))
      ##1 !$rose(watchdog_expired_i) ##1 (rd22 && !$rose(watchdog_expired_i)) |=> !rd_data_o[5])
      else $error("flag not cleared by read");
   read_pulse_a: assert property (rd_en_i ##1 !rd_en_i |-> rd_valid_o ##1 !rd_valid_o)
      else $error("read valid pulse wrong");
endmodule
bind charger_fault_and_event_flags charger_flags_properties i_chk (.*);

// [test/flag_reader_host.sv]
`timescale 1ns/1ns
module flag_reader_host (
   input wire clk_i,
   output logic rd_en_o,
   output logic [7:0] rd_addr_o,
   input wire [7:0] rd_data_i,
   input wire rd_valid_i
);
   initial begin
      rd_en_o = 1'b0;
      rd_addr_o = 8'h00;
   end
   // Request held through its sampling edge, then the address is scrambled
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int n;
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk_i);
      rd_en_o <= 1'b1;
      rd_addr_o <= a;
      @(posedge clk_i);
      rd_en_o <= 1'b0;
      rd_addr_o <= ~a;
      for (n = 0; n < 4 && !ok; n++) begin
         @(negedge clk_i);
         if (rd_valid_i === 1'b1) begin
            ok = 1'b1;
            d = rd_data_i;
         end
      end
   endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ns
module tb;
   logic clk_i, reset_i, rd_en, rd_valid, ok;
   logic [7:0] rd_addr, rd_data, d;
   logic [37:0] v;
   int n_mismatch, cmp_count, i;
   logic [23:0] rows [0:27] = '{
      24'h002180, 24'h012140, 24'h022120, 24'h032110, 24'h042104,
      24'h052280, 24'h062280, 24'h072240, 24'h082240, 24'h092220, 24'h0a2210,
      24'h0b2208, 24'h0c2204, 24'h0d2202, 24'h0e2201, 24'h0f2304, 24'h102302,
      24'h112440, 24'h122410, 24'h132408, 24'h142404, 24'h152402, 24'h162401,
      24'h172400, 24'h192380, 24'h1c2340, 24'h1e2310, 24'h222301};
   flag_reader_host i_flag_reader_host (.clk_i(clk_i), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
      .rd_data_i(rd_data), .rd_valid_i(rd_valid));
   charger_fault_and_event_flags i_charger_fault_and_event_flags (.clk_i(clk_i), .reset_i(reset_i),
      .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .system_rail_short_state_i(v[0]), .system_rail_overvolt_state_i(v[1]),
      .otg_output_overvolt_state_i(v[2]), .otg_output_undervolt_state_i(v[3]), .die_shutdown_state_i(v[4]),
      .input_current_regulation_i(v[5]), .otg_current_regulation_i(v[6]), .input_voltage_regulation_i(v[7]),
      .otg_voltage_regulation_i(v[8]), .watchdog_expired_i(v[9]), .weak_source_i(v[10]),
      .power_good_state_i(v[11]), .second_input_present_i(v[12]), .first_input_present_i(v[13]),
      .bus_input_present_i(v[14]), .die_temp_regulation_i(v[15]), .battery_present_i(v[16]),
      .data_line_detect_complete_i(v[17]), .minimum_system_voltage_i(v[18]),
      .fast_charge_timer_expired_i(v[19]), .trickle_timer_expired_i(v[20]),
      .precharge_timer_expired_i(v[21]), .final_phase_timer_expired_i(v[22]), .conversion_done_i(v[23]),
      .single_conversion_mode_i(v[24]), .charge_state_i(v[27:25]), .input_current_optimizer_i(v[29:28]),
      .bus_source_type_i(v[33:30]), .port_detection_i(v[37:34]));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Read one register and compare with the expected byte
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      i_flag_reader_host.rd(a, d, ok);
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("BAD read_valid expected 1 seen %b", ok);
         close_out;
      end
      cmp_count++;
      if (d !== exp) begin
         n_mismatch++;
         $display("BAD reg_%h expected %h seen %h", a, exp, d);
      end
   endtask
   // Drop all inputs and empty the flag registers
   task automatic clr;
      @(posedge clk_i);
      v <= '0;
      for (int k = 8'h22; k < 8'h25; k++)
         i_flag_reader_host.rd(k[7:0], d, ok);
   endtask
   initial begin
      n_mismatch = 0;
      cmp_count = 0;
      v = '0;
      reset_i = 1'b1;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      for (i = 0; i < 28; i++) begin
         @(posedge clk_i);
         v <= 38'h1 << rows[i][23:16];
         rc(rows[i][15:8], rows[i][7:0]);
         clr;
      end
      $display("event table done");
      @(posedge clk_i);
      v <= (38'h1 << 23) | (38'h1 << 24);
      rc(8'h24, 8'h20);
      clr;
      @(posedge clk_i);
      v <= (38'h1 << 11) | (38'h1 << 18);
      rc(8'h22, 8'h08);
      rc(8'h24, 8'h10);
      @(posedge clk_i);
      v <= '0;
      rc(8'h22, 8'h08);
      rc(8'h24, 8'h10);
      $display("falling edge test done");
      @(posedge clk_i);
      v <= 38'h1 << 9;
      rc(8'h22, 8'h20);
      rc(8'h22, 8'h00);
      rc(8'h22, 8'h00);
      clr;
      $display("clear on read test done");
      @(posedge clk_i);
      v <= 38'h1 << 9;
      @(posedge clk_i);
      v <= '0;
      reset_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      for (i = 8'h21; i < 8'h25; i++)
         rc(i[7:0], 8'h00);
      rc(8'h30, 8'h00);
      $display("reset test done");
      close_out;
   end
endmodule
